//--- ulses_event_select.sv
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// R1 - 06H/08H: local read-invalidate, modified forwarded
// R2 - Mask 10H under 06H/07H: conflict responses
// R3 - Mask 20H: read snoops hitting modified
// R4 - 07H/01H: remote responses, line absent
// R5 - 07H/02H: remote responses, line shared
// R6 - 07H/04H: remote read snoop hits exclusive
// R7 - 07H/08H: remote read-invalidate hits modified
// R8 - 07H/24H: remote modified-hit responses
// R9 - 08H: read hits, writeback hits
// R10 - 08H/03H: any read or write hit
// R11 - 09H: read misses, writeback misses
// R12 - 09H/03H: any read or write miss; the code counts only read misses here
// R13 - Writeback misses never counted, inclusive cache
// R14 - Mask 04H: probe hits or misses
// R15 - 0AH: allocations by modified/exclusive/shared state
// R16 - Modified allocation only from read-invalidate-own
// R17 - 06H/04H: local read snoop hits exclusive
// R18 - 0AH/0FH: allocations in any state
// R19 - One per cycle with any qualifying occurrence; masks OR
module ulses_event_select (
    // Clock and reset
    input  wire logic                      clock,
    input  wire logic                      rst_n,
    // Occurrences from the cache and snoop pipelines
    input  wire ulses_pkg::ulses_snoop_type snoop_in,
    input  wire logic                      snoop_valid,
    input  wire ulses_pkg::ulses_llc_type   llc_in,
    input  wire ulses_pkg::ulses_alloc_type alloc_in,
    // AXI4-Lite write address
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    input  wire logic [3:0]                s_axi_awaddr,
    // AXI4-Lite write data
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    // AXI4-Lite write response
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    output logic [1:0]                     s_axi_bresp,
    // AXI4-Lite read address
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    input  wire logic [3:0]                s_axi_araddr,
    // AXI4-Lite read data
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready,
    output logic [31:0]                    s_axi_rdata,
    output logic [1:0]                     s_axi_rresp,
    // Count increment for the counter, one cycle
    output logic                           count_inc
);

    typedef struct packed {
        logic [7:0]  event_sel;
        logic [7:0]  mask_sel;
        logic [31:0] count;
        logic        inc;
        logic        aw_held;
        logic [3:0]  aw_addr;
        logic        w_held;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        wb_miss_seen;
        logic        awready;
        logic        wready;
        logic        arready;
    } ulses_state_type;

    ulses_state_type state_r;
    ulses_state_type state_nxt;

    logic [5:0] snp_hits;
    logic       snp_match;
    logic       llc_match;
    logic       alloc_match;
    logic       qualify;
    logic [3:0] alloc_hits;
    logic       alloc_m_legal;

    // Snoop response decode, per mask bit
    always_comb begin
        snp_hits = '0;
        snp_hits[ulses_pkg::SNP_INVALID_BIT]  = snoop_in.invalid;              // see R4
        snp_hits[ulses_pkg::SNP_SHARED_BIT]   = snoop_in.shared;               // see R5
        snp_hits[ulses_pkg::SNP_FWD_S_BIT]    = snoop_in.forward_shared_response;      // see R6 see R17
        snp_hits[ulses_pkg::SNP_FWD_I_BIT]    = snoop_in.forward_invalidate_response;  // see R1 see R7
        snp_hits[ulses_pkg::SNP_CONFLICT_BIT] = snoop_in.conflict;             // see R2
        snp_hits[ulses_pkg::SNP_WB_BIT]       = snoop_in.writeback_response;   // see R3
    end

    // Mask 24H on remote is the union of its two bits, so modified-hit falls out of the OR
    always_comb begin
        snp_match = 1'b0;
        if (snoop_valid && ((state_r.event_sel == ulses_pkg::EV_SNP_LOCAL && snoop_in.local_home) ||
                (state_r.event_sel == ulses_pkg::EV_SNP_REMOTE && !snoop_in.local_home))) begin
            snp_match = |(snp_hits & state_r.mask_sel[5:0]);                   // see R8 see R19
        end
    end

    always_comb begin
        llc_match = 1'b0;
        if (state_r.event_sel == ulses_pkg::EV_LLC_HIT) begin
            llc_match = (state_r.mask_sel[ulses_pkg::LLC_READ_BIT] && llc_in.read_hit) ||     // see R9 see R10
                        (state_r.mask_sel[ulses_pkg::LLC_WRITE_BIT] && llc_in.write_hit) ||
                        (state_r.mask_sel[ulses_pkg::LLC_PROBE_BIT] && llc_in.probe_hit);     // see R14
        end else if (state_r.event_sel == ulses_pkg::EV_LLC_MISS) begin
            // Inclusive cache: a writeback miss report is not counted, only latched in wb_miss_seen
            llc_match = (state_r.mask_sel[ulses_pkg::LLC_READ_BIT] && llc_in.read_miss) ||    // see R11 see R12
                        (state_r.mask_sel[ulses_pkg::LLC_PROBE_BIT] && llc_in.probe_miss);    // see R13 see R14
        end
    end

    // Modified allocation only legal when forwarded by read-invalidate-own
    assign alloc_m_legal = alloc_in.alloc_from_rdinv_own;                      // see R16

    always_comb begin
        alloc_hits = '0;
        if (alloc_in.alloc_valid) begin
            unique case (alloc_in.alloc_state)
                ulses_pkg::ALLOC_STATE_M: alloc_hits[ulses_pkg::ALLOC_M_BIT] = alloc_m_legal;
                ulses_pkg::ALLOC_STATE_E: alloc_hits[ulses_pkg::ALLOC_E_BIT] = 1'b1;
                ulses_pkg::ALLOC_STATE_S: alloc_hits[ulses_pkg::ALLOC_S_BIT] = 1'b1;
                ulses_pkg::ALLOC_STATE_F: alloc_hits[ulses_pkg::ALLOC_F_BIT] = 1'b1;
            endcase
        end
    end

    assign alloc_match = (state_r.event_sel == ulses_pkg::EV_LLC_ALLOC) &&
                         |(alloc_hits & state_r.mask_sel[3:0]);                // see R15 see R18

    assign qualify = snp_match || llc_match || alloc_match;

    always_comb begin
        state_nxt = state_r;
        state_nxt.inc = qualify;                                               // see R19
        if (llc_in.write_miss) begin
            state_nxt.wb_miss_seen = 1'b1;
        end

        // Write channel: address and data taken in either order
        if (s_axi_awvalid && !state_r.aw_held && !state_r.bvalid) begin
            state_nxt.aw_held = 1'b1;
            state_nxt.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !state_r.w_held && !state_r.bvalid) begin
            state_nxt.w_held = 1'b1;
            state_nxt.w_data = s_axi_wdata;
            state_nxt.w_strb = s_axi_wstrb;
        end

        // Counter runs before a software write, so a write in the same cycle wins
        if (qualify) begin
            state_nxt.count = state_r.count + 32'h0000_0001;                   // see R19
        end

        if (state_r.aw_held && state_r.w_held) begin
            state_nxt.aw_held = 1'b0;
            state_nxt.w_held  = 1'b0;
            state_nxt.bvalid  = 1'b1;
            state_nxt.bresp   = ulses_pkg::RESP_OKAY;
            unique case (state_r.aw_addr)
                ulses_pkg::ADDR_SELECT: begin
                    if (state_r.w_strb[0]) begin
                        state_nxt.event_sel = state_r.w_data[7:0];
                    end
                    if (state_r.w_strb[1]) begin
                        state_nxt.mask_sel = state_r.w_data[15:8];
                    end
                end
                ulses_pkg::ADDR_COUNT: begin
                    for (int b = 0; b < 4; b++) begin
                        if (state_r.w_strb[b]) begin
                            state_nxt.count[8*b +: 8] = state_r.w_data[8*b +: 8];
                        end
                    end
                end
                ulses_pkg::ADDR_STATUS: begin
                    // Writing one clears the sticky writeback-miss flag unless a writeback miss arrives in the same cycle
                    if (state_r.w_strb[0] && state_r.w_data[0] && !llc_in.write_miss) begin
                        state_nxt.wb_miss_seen = 1'b0;
                    end
                end
                default: state_nxt.bresp = ulses_pkg::RESP_SLVERR;
            endcase
        end
        if (state_r.bvalid && s_axi_bready) begin
            state_nxt.bvalid = 1'b0;
        end

        // Read channel: one-cycle accept, data in the next
        if (s_axi_arvalid && !state_r.rvalid) begin
            state_nxt.rvalid = 1'b1;
            state_nxt.rresp  = ulses_pkg::RESP_OKAY;
            unique case (s_axi_araddr)
                ulses_pkg::ADDR_SELECT: state_nxt.rdata = {16'h0000, state_r.mask_sel, state_r.event_sel};
                ulses_pkg::ADDR_COUNT:  state_nxt.rdata = state_r.count;
                ulses_pkg::ADDR_STATUS: state_nxt.rdata = {31'h0000_0000, state_r.wb_miss_seen};
                default: begin
                    state_nxt.rdata = 32'h0000_0000;
                    state_nxt.rresp = ulses_pkg::RESP_SLVERR;
                end
            endcase
        end else if (state_r.rvalid && s_axi_rready) begin
            state_nxt.rvalid = 1'b0;
        end

        // Ready flags registered so every bus output leaves a flip-flop
        state_nxt.awready = !state_nxt.aw_held && !state_nxt.bvalid;
        state_nxt.wready  = !state_nxt.w_held && !state_nxt.bvalid;
        state_nxt.arready = !state_nxt.rvalid;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_r              <= '0;
            state_r.event_sel    <= ulses_pkg::SELECT_EVENT_RST;
            state_r.mask_sel     <= ulses_pkg::SELECT_MASK_RST;
            state_r.count        <= ulses_pkg::COUNT_RST;
            state_r.awready      <= 1'b1;
            state_r.wready       <= 1'b1;
            state_r.arready      <= 1'b1;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign s_axi_awready = state_r.awready;
    assign s_axi_wready  = state_r.wready;
    assign s_axi_bvalid  = state_r.bvalid;
    assign s_axi_bresp   = state_r.bresp;
    assign s_axi_arready = state_r.arready;
    assign s_axi_rvalid  = state_r.rvalid;
    assign s_axi_rdata   = state_r.rdata;
    assign s_axi_rresp   = state_r.rresp;
    assign count_inc     = state_r.inc;

endmodule : ulses_event_select

`default_nettype wire

//--- ulses_pkg.sv
package ulses_pkg;

    // Event numbers
    localparam logic [7:0] EV_SNP_LOCAL  = 8'h06;
    localparam logic [7:0] EV_SNP_REMOTE = 8'h07;
    localparam logic [7:0] EV_LLC_HIT    = 8'h08;
    localparam logic [7:0] EV_LLC_MISS   = 8'h09;
    localparam logic [7:0] EV_LLC_ALLOC  = 8'h0A;

    // Unit-mask bits, snoop response events
    localparam int SNP_INVALID_BIT  = 0;
    localparam int SNP_SHARED_BIT   = 1;
    localparam int SNP_FWD_S_BIT    = 2;
    localparam int SNP_FWD_I_BIT    = 3;
    localparam int SNP_CONFLICT_BIT = 4;
    localparam int SNP_WB_BIT       = 5;

    // Unit-mask bits, hit and miss events
    localparam int LLC_READ_BIT  = 0;
    localparam int LLC_WRITE_BIT = 1;
    localparam int LLC_PROBE_BIT = 2;

    // Unit-mask bits, allocation event
    localparam int ALLOC_M_BIT = 0;
    localparam int ALLOC_E_BIT = 1;
    localparam int ALLOC_S_BIT = 2;
    localparam int ALLOC_F_BIT = 3;

    // Register map, byte addresses
    localparam logic [3:0] ADDR_SELECT  = 4'h0;
    localparam logic [3:0] ADDR_COUNT   = 4'h4;
    localparam logic [3:0] ADDR_STATUS  = 4'h8;

    localparam logic [7:0]  SELECT_EVENT_RST = 8'h00;
    localparam logic [7:0]  SELECT_MASK_RST  = 8'h00;
    localparam logic [31:0] COUNT_RST        = 32'h0000_0000;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // One cycle's occurrences reported by the cache and snoop pipelines
    typedef struct packed {
        logic local_home;
        logic invalid;
        logic shared;
        logic forward_shared_response;
        logic forward_invalidate_response;
        logic conflict;
        logic writeback_response;
    } ulses_snoop_type;

    typedef struct packed {
        logic read_hit;
        logic write_hit;
        logic probe_hit;
        logic read_miss;
        logic write_miss;
        logic probe_miss;
    } ulses_llc_type;

    typedef struct packed {
        logic alloc_valid;
        logic [1:0] alloc_state;
        logic alloc_from_rdinv_own;
    } ulses_alloc_type;

    localparam logic [1:0] ALLOC_STATE_M = 2'h0;
    localparam logic [1:0] ALLOC_STATE_E = 2'h1;
    localparam logic [1:0] ALLOC_STATE_S = 2'h2;
    localparam logic [1:0] ALLOC_STATE_F = 2'h3;

endpackage : ulses_pkg

//--- ulses_event_select_properties.sv
`timescale 1ns/1ps
`default_nettype none
module ulses_event_select_properties (
    // Clock and reset
    input wire logic                       clock,
    input wire logic                       rst_n,
    // Occurrences
    input wire ulses_pkg::ulses_snoop_type snoop_in,
    input wire logic                       snoop_valid,
    input wire ulses_pkg::ulses_llc_type   llc_in,
    input wire ulses_pkg::ulses_alloc_type alloc_in,
    // Register writes
    input wire logic                       s_axi_awvalid,
    input wire logic                       s_axi_awready,
    input wire logic [3:0]                 s_axi_awaddr,
    input wire logic                       s_axi_wvalid,
    input wire logic                       s_axi_wready,
    input wire logic [31:0]                s_axi_wdata,
    input wire logic                       s_axi_bvalid,
    // Result
    input wire logic                       count_inc
);
    logic [3:0]  addr_r;
    logic [15:0] data_r;
    logic [15:0] sel_r;
    // Only trusted with no write in flight; full-word writes assumed
    wire ok = s_axi_awready && s_axi_wready && !s_axi_bvalid;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            addr_r <= 4'h0;
            data_r <= 16'h0000;
            sel_r <= 16'h0000;
        end else begin
            if (s_axi_awvalid && s_axi_awready) addr_r <= s_axi_awaddr;
            if (s_axi_wvalid && s_axi_wready) data_r <= s_axi_wdata[15:0];
            if (s_axi_bvalid && addr_r == ulses_pkg::ADDR_SELECT) sel_r <= data_r;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    property p_wb_miss; ok && sel_r == 16'h0209 |=> !count_inc; endproperty
    a_wb_miss: assert property (p_wb_miss) else $error("writeback miss counted");
    property p_read_hit; ok && sel_r == 16'h0108 && llc_in.read_hit |=> count_inc; endproperty
    a_read_hit: assert property (p_read_hit) else $error("read hit not counted");
    property p_any_miss; ok && sel_r == 16'h0309 |=> count_inc == $past(llc_in.read_miss); endproperty
    a_any_miss: assert property (p_any_miss) else $error("any-miss count wrong");
    property p_probe_hit; ok && sel_r == 16'h0408 |=> count_inc == $past(llc_in.probe_hit); endproperty
    a_probe_hit: assert property (p_probe_hit) else $error("probe hit count wrong");
    property p_m_alloc;
        ok && sel_r == 16'h010A && alloc_in.alloc_state == 2'h0 && !alloc_in.alloc_from_rdinv_own |=> !count_inc;
    endproperty
    a_m_alloc: assert property (p_m_alloc) else $error("modified allocation without own");
    property p_conflict;
        ok && sel_r == 16'h1007 && snoop_valid && !snoop_in.local_home && snoop_in.conflict |=> count_inc;
    endproperty
    a_conflict: assert property (p_conflict) else $error("conflict not counted");
    property p_local_only; ok && sel_r == 16'h0806 && !(snoop_valid && snoop_in.local_home) |=> !count_inc; endproperty
    a_local_only: assert property (p_local_only) else $error("non-local response counted");
    property p_alloc_s;
        ok && sel_r == 16'h040A |=> count_inc == ($past(alloc_in.alloc_valid) && $past(alloc_in.alloc_state) == 2'h2);
    endproperty
    a_alloc_s: assert property (p_alloc_s) else $error("shared allocation count wrong");
    c_modified_hit_response: cover property (sel_r == 16'h2407 && count_inc);
    c_any_alloc: cover property (ok && sel_r == 16'h0F0A && count_inc);
    c_burst: cover property (count_inc ##1 count_inc);
endmodule : ulses_event_select_properties
bind ulses_event_select ulses_event_select_properties u_props (.clock, .rst_n, .snoop_in, .snoop_valid, .llc_in,
    .alloc_in, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
    .s_axi_bvalid, .count_inc);
`default_nettype wire

//--- ulses_cache_model.sv
`timescale 1ns/1ps
`default_nettype none
module ulses_cache_model (
    // Random source and control
    input  wire logic [31:0]               rnd,
    input  wire logic                      run,
    input  wire logic                      fault,
    // Occurrences toward the selector
    output var ulses_pkg::ulses_snoop_type snoop_in,
    output logic                           snoop_valid,
    output var ulses_pkg::ulses_llc_type   llc_in,
    output var ulses_pkg::ulses_alloc_type alloc_in
);
    always_comb begin
        snoop_in = rnd[6:0];
        snoop_valid = run && rnd[7];
        llc_in = run ? rnd[13:8] : 6'h00;
        alloc_in = run ? rnd[17:14] : 4'h0;
        // Inclusive cache: a writeback miss only when a fault is commanded
        if (!fault) llc_in.write_miss = 1'b0;
        if (!fault && alloc_in.alloc_state == 2'h0) alloc_in.alloc_from_rdinv_own = 1'b1;
    end
endmodule : ulses_cache_model
`default_nettype wire

//--- test_uncore_l3_snoop_event_select.sv
`timescale 1ns/1ps
`default_nettype none
module test_uncore_l3_snoop_event_select;
    logic clock = 0, rst_n = 0, run = 0, fault = 0, wbm = 0, snoop_valid, count_inc;
    logic [31:0] rnd = 0, s_axi_wdata = 0, s_axi_rdata;
    logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [7:0] ev = 0, mk = 0;
    ulses_pkg::ulses_snoop_type snoop_in;
    ulses_pkg::ulses_llc_type llc_in;
    ulses_pkg::ulses_alloc_type alloc_in;
    int n_errors = 0, samples_checked = 0, total = 0;
    logic [33:0] rq[$];
    logic [1:0] bq[$];
    logic eq[$];
    logic [16:0] tab [24] = '{17'h00608, 17'h00610, 17'h00710, 17'h00620, 17'h00720,
        17'h00701, 17'h00702, 17'h00704, 17'h00708, 17'h00724, 17'h00604,
        17'h00801, 17'h00802, 17'h00803, 17'h00901, 17'h10902, 17'h10903,
        17'h00804, 17'h00904, 17'h10A01, 17'h00A01, 17'h00A02, 17'h00A04, 17'h00A0F};
    always #10 clock = ~clock;
    ulses_event_select u_ulses_event_select (.clock, .rst_n, .snoop_in, .snoop_valid, .llc_in, .alloc_in,
        .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
        .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .count_inc);
    ulses_cache_model u_ulses_cache_model (.rnd, .run, .fault, .snoop_in, .snoop_valid, .llc_in, .alloc_in);
    function automatic logic hit();
        logic [5:0] s;
        logic [2:0] h, m;
        logic [3:0] a;
        s = {<<{snoop_in[5:0]}};
        h = {<<{llc_in[5:3]}};
        m = {<<{llc_in[2:0]}};
        a = (4'h1 << alloc_in.alloc_state) & {4{alloc_in.alloc_valid}};
        if (alloc_in.alloc_state == ulses_pkg::ALLOC_STATE_M && !alloc_in.alloc_from_rdinv_own) a = 4'h0;
        case (ev)
            8'h06, 8'h07: return snoop_valid && snoop_in.local_home == (ev == 8'h06) && |(s & mk[5:0]);
            8'h08: return |(h & mk[2:0]);
            8'h09: return |(m & 3'h5 & mk[2:0]);
            8'h0A: return |(a & mk[3:0]);
            default: return 1'b0;
        endcase
    endfunction : hit
    task automatic check(input logic [33:0] got, input logic [33:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        bq.push_back(r);
        do begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [33:0] e);
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        rq.push_back(e);
        do @(posedge clock); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge clock); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask : rd
    task automatic print_verdict();
        if (n_errors == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : print_verdict
    always @(posedge clock) begin
        if (eq.size() > 0) check({33'h0, count_inc}, {33'h0, eq.pop_front()});
        if (s_axi_rvalid && s_axi_rready) check({s_axi_rresp, s_axi_rdata}, rq.pop_front());
        if (s_axi_bvalid && s_axi_bready) check({32'h0, s_axi_bresp}, {32'h0, bq.pop_front()});
        if (run) begin
            eq.push_back(hit());
            total += int'(hit());
            wbm |= llc_in.write_miss;
        end
    end
    initial begin
        void'($urandom(32'h3AFC));
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        foreach (tab[i]) begin
            ev = tab[i][15:8];
            mk = tab[i][7:0];
            wr(ulses_pkg::ADDR_SELECT, {16'h0000, mk, ev}, ulses_pkg::RESP_OKAY);
            wr(ulses_pkg::ADDR_COUNT, 32'h0000_0000, ulses_pkg::RESP_OKAY);
            total = 0;
            fault <= tab[i][16];
            run <= 1'b1;
            repeat (40) begin
                rnd <= $urandom;
                @(posedge clock);
            end
            run <= 1'b0;
            @(posedge clock);
            rd(ulses_pkg::ADDR_COUNT, {2'h0, total[31:0]});
        end
        rd(ulses_pkg::ADDR_STATUS, {33'h0, wbm});
        wr(ulses_pkg::ADDR_STATUS, 32'h0000_0001, ulses_pkg::RESP_OKAY);
        rd(ulses_pkg::ADDR_STATUS, 34'h0);
        wr(4'hC, 32'h0000_0000, ulses_pkg::RESP_SLVERR);
        rd(4'hC, {ulses_pkg::RESP_SLVERR, 32'h0000_0000});
        print_verdict();
    end
    initial begin
        repeat (5000) @(posedge clock);
        n_errors++;
        print_verdict();
    end
endmodule : test_uncore_l3_snoop_event_select
`default_nettype wire
